//--- hw/atw_slave.sv
// slave end: condition detection, address match, acknowledge, setup and
// configuration registers, speed mode tracking
// assumes the link lines are asynchronous to pclk and much slower than it
`timescale 1ns/1ps
`default_nettype none
module atw_slave (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   // link
   atw_if.slave link,
   // register fields
   output logic [2:0] reference_select,
   output logic ext_clock_select,
   output logic polarity_select,
   output logic [1:0] scan_select,
   output logic [3:0] channel_select,
   output logic input_mode_select,
   // status
   output logic hs_mode,
   output logic read_request,
   output logic busy
);
   logic scl_s1, scl_s2, scl_d;
   logic sda_s1, sda_s2, sda_d;
   logic scl_rise, scl_fall, start_seen, stop_seen;
   logic [3:0] bit_cnt;
   logic [7:0] shreg;
   logic rw_bit;
   logic mc_pending;
   logic sda_low;
   logic byte_done, ack_end, addr_hit;
   atw_pkg::atw_slv_state_t state;

   // two-stage synchronisers, then one delay for edges
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         scl_s1 <= 1'b1;
         scl_s2 <= 1'b1;
         scl_d <= 1'b1;
         sda_s1 <= 1'b1;
         sda_s2 <= 1'b1;
         sda_d <= 1'b1;
      end
      else if (ce)
      begin
         scl_s1 <= link.scl;
         scl_s2 <= scl_s1;
         scl_d <= scl_s2;
         sda_s1 <= link.sda;
         sda_s2 <= sda_s1;
         sda_d <= sda_s2;
      end
   end

   // edge and condition decode
   assign scl_rise = scl_s2 & ~scl_d;
   assign scl_fall = ~scl_s2 & scl_d;
   assign start_seen = scl_s2 & scl_d & sda_d & ~sda_s2;
   assign stop_seen = scl_s2 & scl_d & ~sda_d & sda_s2;
   assign byte_done = scl_fall && bit_cnt == atw_pkg::BITS_PER_BYTE
                      && (state == atw_pkg::S_ADDR || state == atw_pkg::S_DATA);
   assign ack_end = scl_fall && (state == atw_pkg::S_ADDR_ACK || state == atw_pkg::S_DATA_ACK);
   assign addr_hit = shreg[7:1] == atw_pkg::SLAVE_ADDR;

   // byte sequencer; data sampled on clock rise, one bit per period
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state <= atw_pkg::S_IDLE;
         bit_cnt <= 4'h0;
         shreg <= 8'h00;
         rw_bit <= 1'b0;
         mc_pending <= 1'b0;
      end
      else if (ce)
      begin
         if (start_seen)
         begin
            state <= atw_pkg::S_ADDR;
            bit_cnt <= 4'h0;
            mc_pending <= 1'b0;
         end
         else if (stop_seen)
         begin
            state <= atw_pkg::S_IDLE;
            bit_cnt <= 4'h0;
            mc_pending <= 1'b0;
         end
         else
         begin
            case (state)
               atw_pkg::S_ADDR, atw_pkg::S_DATA:
               begin
                  if (scl_rise && bit_cnt < atw_pkg::BITS_PER_BYTE)
                  begin
                     shreg <= {shreg[6:0], sda_s2};
                     bit_cnt <= bit_cnt + 4'h1;
                  end
                  if (byte_done && state == atw_pkg::S_ADDR)
                  begin
                     if (addr_hit)
                     begin
                        state <= atw_pkg::S_ADDR_ACK;
                        rw_bit <= shreg[0];
                     end
                     else if (atw_pkg::is_master_code(shreg))
                     begin
                        state <= atw_pkg::S_ADDR_ACK;
                        mc_pending <= 1'b1;
                     end
                     else
                        state <= atw_pkg::S_SKIP;
                  end
                  else if (byte_done)
                     state <= atw_pkg::S_DATA_ACK;
               end
               atw_pkg::S_ADDR_ACK:
               begin
                  if (ack_end)
                  begin
                     bit_cnt <= 4'h0;
                     mc_pending <= 1'b0;
                     if (mc_pending || rw_bit)
                        state <= atw_pkg::S_SKIP;
                     else
                        state <= atw_pkg::S_DATA;
                  end
               end
               atw_pkg::S_DATA_ACK:
               begin
                  if (ack_end)
                  begin
                     bit_cnt <= 4'h0;
                     state <= atw_pkg::S_DATA;
                  end
               end
               atw_pkg::S_IDLE, atw_pkg::S_SKIP:
                  bit_cnt <= 4'h0;
               default:
                  state <= atw_pkg::S_IDLE;
            endcase
         end
      end
   end

   // acknowledge drive: low from eighth fall to ninth fall
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         sda_low <= 1'b0;
      else if (ce)
      begin
         if (start_seen || stop_seen || ack_end)
            sda_low <= 1'b0;
         else if (byte_done && state == atw_pkg::S_DATA)
            sda_low <= 1'b1;
         else if (byte_done && addr_hit)
            sda_low <= 1'b1;
      end
   end

   // output stage of the open-drain data pin
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         link.s_sda_o <= 1'b0;
         link.s_sda_oe_n <= 1'b1;
      end
      else if (ce)
      begin
         link.s_sda_o <= 1'b0;
         link.s_sda_oe_n <= ~sda_low;
      end
   end

   // speed mode; repeated start leaves it alone
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         hs_mode <= 1'b0;
      else if (ce)
      begin
         if (stop_seen)
            hs_mode <= 1'b0;
         else if (ack_end && state == atw_pkg::S_ADDR_ACK && mc_pending)
            hs_mode <= 1'b1;
      end
   end

   // setup register, written at the end of an acknowledged data byte with bit 7 set
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         reference_select <= atw_pkg::REF_SEL_RESET;
         ext_clock_select <= atw_pkg::CLK_SEL_RESET;
         polarity_select <= atw_pkg::POL_SEL_RESET;
      end
      else if (ce && ack_end && state == atw_pkg::S_DATA_ACK
               && shreg[atw_pkg::SETUP_REG_BIT])
      begin
         reference_select <= shreg[atw_pkg::SETUP_REF_HI:atw_pkg::SETUP_REF_LO];
         ext_clock_select <= shreg[atw_pkg::SETUP_CLK_BIT];
         polarity_select <= shreg[atw_pkg::SETUP_POL_BIT];
      end
   end

   // configuration register and its reset from a setup byte
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         scan_select <= atw_pkg::SCAN_RESET;
         channel_select <= atw_pkg::CHAN_RESET;
         input_mode_select <= atw_pkg::MODE_RESET;
      end
      else if (ce && ack_end && state == atw_pkg::S_DATA_ACK)
      begin
         if (!shreg[atw_pkg::SETUP_REG_BIT])
         begin
            scan_select <= shreg[atw_pkg::CFG_SCAN_HI:atw_pkg::CFG_SCAN_LO];
            channel_select <= shreg[atw_pkg::CFG_CHAN_HI:atw_pkg::CFG_CHAN_LO];
            input_mode_select <= shreg[atw_pkg::CFG_MODE_BIT];
         end
         else if (!shreg[atw_pkg::SETUP_RST_BIT])
         begin
            scan_select <= atw_pkg::SCAN_RESET;
            channel_select <= atw_pkg::CHAN_RESET;
            input_mode_select <= atw_pkg::MODE_RESET;
         end
      end
   end

   // status flags
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         read_request <= 1'b0;
         busy <= 1'b0;
      end
      else if (ce)
      begin
         read_request <= ack_end && state == atw_pkg::S_ADDR_ACK && rw_bit && !mc_pending;
         busy <= state != atw_pkg::S_IDLE;
      end
   end
endmodule
`default_nettype wire

//--- hw/atw_pkg.sv
// constants and types shared by both ends of the two-wire setup link
// assumes a 100 MHz pclk on both ends; link pins are open drain
package atw_pkg;
   // slave address, arbitrary value
   localparam logic [6:0] SLAVE_ADDR = 7'h55;
   // master code pattern on the top five bits
   localparam logic [4:0] MCODE_TOP = 5'h01;
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   // setup byte fields
   localparam int SETUP_REG_BIT = 7;
   localparam int SETUP_REF_HI = 6;
   localparam int SETUP_REF_LO = 4;
   localparam int SETUP_CLK_BIT = 3;
   localparam int SETUP_POL_BIT = 2;
   localparam int SETUP_RST_BIT = 1;
   localparam logic [2:0] REF_SEL_RESET = 3'h0;
   localparam logic CLK_SEL_RESET = 1'b0;
   localparam logic POL_SEL_RESET = 1'b0;
   // configuration byte fields and defaults
   localparam int CFG_SCAN_HI = 6;
   localparam int CFG_SCAN_LO = 5;
   localparam int CFG_CHAN_HI = 4;
   localparam int CFG_CHAN_LO = 1;
   localparam int CFG_MODE_BIT = 0;
   localparam logic [1:0] SCAN_RESET = 2'h0;
   localparam logic [3:0] CHAN_RESET = 4'h0;
   localparam logic MODE_RESET = 1'b1;
   // host timing
   localparam int PCLK_KHZ = 100000;
   localparam int FS_SCL_KHZ = 400;
   localparam int HS_SCL_KHZ = 1700;
   localparam logic [7:0] FS_QTR_CYC = 8'((PCLK_KHZ + 4 * FS_SCL_KHZ - 1) / (4 * FS_SCL_KHZ));
   localparam logic [7:0] HS_QTR_CYC = 8'((PCLK_KHZ + 4 * HS_SCL_KHZ - 1) / (4 * HS_SCL_KHZ));
   // host apb map
   localparam logic [7:0] CMD_OFFS = 8'h00;
   localparam logic [7:0] STAT_OFFS = 8'h04;
   localparam logic [1:0] OP_START = 2'h1;
   localparam logic [1:0] OP_BYTE = 2'h2;
   localparam logic [1:0] OP_STOP = 2'h3;
   localparam int CMD_HS_BIT = 2;
   // slave states
   typedef enum logic [5:0] {
      S_IDLE = 6'b00_0001,
      S_ADDR = 6'b00_0010,
      S_ADDR_ACK = 6'b00_0100,
      S_DATA = 6'b00_1000,
      S_DATA_ACK = 6'b01_0000,
      S_SKIP = 6'b10_0000
   } atw_slv_state_t;
   // host states
   typedef enum logic [3:0] {
      H_IDLE = 4'b0001,
      H_START = 4'b0010,
      H_BIT = 4'b0100,
      H_STOP = 4'b1000
   } atw_host_state_t;
   // top five bits of a received address byte form the master code
   function automatic logic is_master_code(input logic [7:0] b);
      return b[7:3] == MCODE_TOP;
   endfunction
endpackage

//--- hw/atw_if.sv
// two-wire link between host and slave, open-drain wired-and with pullups
// assumes both ends drive only low; an enable low means driving
`timescale 1ns/1ps
`default_nettype none
interface atw_if;
   logic m_scl_o;
   logic m_scl_oe_n;
   logic m_sda_o;
   logic m_sda_oe_n;
   logic s_sda_o;
   logic s_sda_oe_n;
   logic scl;
   logic sda;
   // pullup resolution of both lines
   assign scl = ~(~m_scl_oe_n & ~m_scl_o);
   assign sda = ~((~m_sda_oe_n & ~m_sda_o) | (~s_sda_oe_n & ~s_sda_o));
   modport master (output m_scl_o, output m_scl_oe_n, output m_sda_o, output m_sda_oe_n,
                   input scl, input sda);
   modport slave (output s_sda_o, output s_sda_oe_n, input scl, input sda);
endinterface
`default_nettype wire

//--- hw/atw_master.sv
// host end: apb-driven two-wire master making the serial clock by division
// assumes no clock stretching by the slave and a single master on the bus
`timescale 1ns/1ps
`default_nettype none
module atw_master (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // link
   atw_if.master link
);
   logic sda_s1, sda_s2;
   logic [7:0] qtimer;
   logic [1:0] quarter;
   logic [3:0] bit_idx;
   logic [7:0] tx_byte;
   logic [1:0] last_op;
   logic hs_sel, acked, scl_low, sda_low, tick;
   logic cmd_wr, hit;
   atw_pkg::atw_host_state_t state;

   assign cmd_wr = psel && penable && pwrite && paddr == atw_pkg::CMD_OFFS;
   assign hit = paddr == atw_pkg::CMD_OFFS || paddr == atw_pkg::STAT_OFFS;
   assign pready = 1'b1;
   assign pslverr = psel && penable && !hit;
   assign tick = qtimer == 8'h00;

   // read data mux, registered
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata <= 32'h0000_0000;
      else if (ce && psel && !penable)
      begin
         if (paddr == atw_pkg::CMD_OFFS)
            prdata <= {16'h0000, tx_byte, 5'h00, hs_sel, last_op};
         else if (paddr == atw_pkg::STAT_OFFS)
            prdata <= {29'h0000_0000, hs_sel, acked, state != atw_pkg::H_IDLE};
         else
            prdata <= 32'h0000_0000;
      end
   end

   // data pin synchroniser; no stretching, so the clock line is not read back
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         sda_s1 <= 1'b1;
         sda_s2 <= 1'b1;
      end
      else if (ce)
      begin
         sda_s1 <= link.sda;
         sda_s2 <= sda_s1;
      end
   end

   // quarter-period divider
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         qtimer <= atw_pkg::FS_QTR_CYC;
      else if (ce)
      begin
         if (state == atw_pkg::H_IDLE || tick)
            qtimer <= hs_sel ? atw_pkg::HS_QTR_CYC : atw_pkg::FS_QTR_CYC;
         else
            qtimer <= qtimer - 8'h01;
      end
   end

   // command register; writes while busy are ignored
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         tx_byte <= 8'h00;
         last_op <= 2'h0;
         hs_sel <= 1'b0;
      end
      else if (ce && cmd_wr && state == atw_pkg::H_IDLE)
      begin
         tx_byte <= pwdata[15:8];
         last_op <= pwdata[1:0];
         hs_sel <= pwdata[atw_pkg::CMD_HS_BIT];
      end
   end

   // sequencer: four quarters per step
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state <= atw_pkg::H_IDLE;
         quarter <= 2'h0;
         bit_idx <= 4'h0;
         scl_low <= 1'b0;
         sda_low <= 1'b0;
         acked <= 1'b0;
      end
      else if (ce)
      begin
         case (state)
            atw_pkg::H_IDLE:
            begin
               quarter <= 2'h0;
               bit_idx <= 4'h0;
               if (cmd_wr && pwdata[1:0] == atw_pkg::OP_START)
                  state <= atw_pkg::H_START;
               else if (cmd_wr && pwdata[1:0] == atw_pkg::OP_BYTE)
                  state <= atw_pkg::H_BIT;
               else if (cmd_wr && pwdata[1:0] == atw_pkg::OP_STOP)
                  state <= atw_pkg::H_STOP;
            end
            atw_pkg::H_START:
               if (tick)
               begin
                  quarter <= quarter + 2'h1;
                  case (quarter)
                     2'h0: sda_low <= 1'b0;
                     2'h1: scl_low <= 1'b0;
                     2'h2: sda_low <= 1'b1;
                     default:
                     begin
                        scl_low <= 1'b1;
                        state <= atw_pkg::H_IDLE;
                     end
                  endcase
               end
            atw_pkg::H_BIT:
               if (tick)
               begin
                  quarter <= quarter + 2'h1;
                  case (quarter)
                     2'h0: sda_low <= bit_idx < 4'h8 && !tx_byte[3'(4'h7 - bit_idx)];
                     2'h1: scl_low <= 1'b0;
                     2'h2: if (bit_idx == 4'h8) acked <= !sda_s2;
                     default:
                     begin
                        scl_low <= 1'b1;
                        bit_idx <= bit_idx + 4'h1;
                        if (bit_idx == 4'h8)
                           state <= atw_pkg::H_IDLE;
                     end
                  endcase
               end
            atw_pkg::H_STOP:
               if (tick)
               begin
                  quarter <= quarter + 2'h1;
                  case (quarter)
                     2'h0: sda_low <= 1'b1;
                     2'h1: scl_low <= 1'b0;
                     2'h2: sda_low <= 1'b0;
                     default: state <= atw_pkg::H_IDLE;
                  endcase
               end
            default:
               state <= atw_pkg::H_IDLE;
         endcase
      end
   end

   // open-drain pin drive
   assign link.m_scl_o = 1'b0;
   assign link.m_sda_o = 1'b0;
   assign link.m_scl_oe_n = ~scl_low;
   assign link.m_sda_oe_n = ~sda_low;
endmodule
`default_nettype wire

//--- bench/atw_chk.sv
// checker for the two-wire link between host end and slave end
// assumes it sits beside the interface and sees its resolved lines and enables
`timescale 1ns/1ps
`default_nettype none
module atw_chk (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // link lines and enables
   input wire logic scl,
   input wire logic sda,
   input wire logic m_scl_oe_n,
   input wire logic m_sda_oe_n,
   input wire logic s_sda_oe_n,
   // slave status
   input wire logic hs_mode,
   input wire logic busy
);
   logic scl_q;
   logic sda_q;
   logic start_seen;
   logic stop_seen;
   // previous line levels
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end
      else
      begin
         scl_q <= scl;
         sda_q <= sda;
      end
   end
   // data edges while the clock stays high
   assign start_seen = scl && scl_q && sda_q && !sda;
   assign stop_seen = scl && scl_q && !sda_q && sda;
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   a_lines_released: assert property ($rose(presetn) |-> m_scl_oe_n && m_sda_oe_n && s_sda_oe_n)
      else $error("line driven right after reset");
   a_slave_stable_high: assert property (scl && scl_q |-> $stable(s_sda_oe_n))
      else $error("slave moved data while clock high");
   a_ack_before_rise: assert property ($fell(s_sda_oe_n) |-> !scl)
      else $error("acknowledge started with clock high");
   a_ack_held: assert property ($fell(s_sda_oe_n) |-> (!s_sda_oe_n)[*8])
      else $error("acknowledge too short");
   a_ack_bounded: assert property ($fell(s_sda_oe_n) |-> ##[20:400] $rose(s_sda_oe_n))
      else $error("acknowledge not released in time");
   a_hs_after_nack: assert property ($rose(hs_mode) |-> s_sda_oe_n && $past(s_sda_oe_n, 8))
      else $error("high speed entered without released data");
   a_sr_keeps_hs: assert property (start_seen && hs_mode |-> hs_mode[*8])
      else $error("repeated start left high speed");
   a_stop_drops_hs: assert property (stop_seen && hs_mode |-> ##[1:6] !hs_mode)
      else $error("stop kept high speed");
   a_start_busy: assert property (start_seen |-> ##[1:6] busy)
      else $error("start not detected");
   a_stop_idle: assert property (stop_seen |-> ##[1:6] !busy)
      else $error("stop not detected");
   a_idle_quiet: assert property (!busy && !$past(busy) |-> s_sda_oe_n)
      else $error("idle slave drives data");
   // main scenarios reached
   c_ack: cover property ($fell(s_sda_oe_n));
   c_hs: cover property ($rose(hs_mode));
   c_hs_stop: cover property (stop_seen && hs_mode);
endmodule
`default_nettype wire

//--- bench/testbench.sv
// self-checking bench: apb commands into the host end, slave end across the link
// assumes package, interface, both ends and the checker are compiled first
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [2:0] reference_select;
   logic ext_clock_select;
   logic polarity_select;
   logic [1:0] scan_select;
   logic [3:0] channel_select;
   logic input_mode_select;
   logic hs_mode;
   logic read_request;
   logic busy;
   logic [8:0] wire_sr = 9'h000;
   logic [31:0] stat = 32'h0000_0000;
   logic last_err = 1'b0;
   logic ce = 1'b1;
   int scl_rises = 0;
   int failures = 0;
   int tests_run = 0;
   int cycles = 0;
   int reads = 0;
   atw_if atw_if_i ();
   atw_master atw_master_i (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .link(atw_if_i.master));
   atw_slave atw_slave_i (.pclk(pclk), .presetn(presetn), .ce(ce), .link(atw_if_i.slave),
      .reference_select(reference_select), .ext_clock_select(ext_clock_select),
      .polarity_select(polarity_select), .scan_select(scan_select),
      .channel_select(channel_select), .input_mode_select(input_mode_select),
      .hs_mode(hs_mode), .read_request(read_request), .busy(busy));
   atw_chk atw_chk_i (.pclk(pclk), .presetn(presetn), .scl(atw_if_i.scl), .sda(atw_if_i.sda),
      .m_scl_oe_n(atw_if_i.m_scl_oe_n), .m_sda_oe_n(atw_if_i.m_sda_oe_n),
      .s_sda_oe_n(atw_if_i.s_sda_oe_n), .hs_mode(hs_mode), .busy(busy));
   // 100 MHz clock
   always #5 pclk = ~pclk;
   // serial bits seen on the wire at each clock rise
   always @(posedge atw_if_i.scl)
   begin
      wire_sr <= {wire_sr[7:0], atw_if_i.sda};
      scl_rises <= scl_rises + 1;
   end
   // read address pulses
   always @(posedge pclk)
      if (read_request === 1'b1)
         reads <= reads + 1;
   // cut a hung run short
   always @(posedge pclk)
   begin
      cycles <= cycles + 1;
      if (cycles == 60000)
      begin
         failures = failures + 1;
         summarize();
      end
   end
   task summarize();
      if (failures == 0 && tests_run > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run = tests_run + 1;
      if (seen !== exp)
      begin
         failures = failures + 1;
         $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask
   // one apb transfer: setup, access until pready
   task apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
         @(posedge pclk);
      q = prdata;
      last_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // command the host end, then poll until it is idle and the slave has settled
   task op(input logic [1:0] code, input logic [7:0] b, input logic hs);
      apb(1'b1, atw_pkg::CMD_OFFS, {16'h0000, b, 5'h00, hs, code}, stat);
      stat = 32'h0000_0001;
      while (stat[0] !== 1'b0)
         apb(1'b0, atw_pkg::STAT_OFFS, 32'h0000_0000, stat);
      repeat (4) @(posedge pclk);
   endtask
   // one byte plus acknowledge, with the wire bits compared
   task send(input logic [7:0] b, input logic hs, output logic ack);
      op(atw_pkg::OP_BYTE, b, hs);
      ack = stat[1];
      check(wire_sr[8:1], b);
      check(wire_sr[0], !ack);
   endtask
   task t_reset();
      check({reference_select, ext_clock_select, polarity_select}, 5'h00);
      check({scan_select, channel_select, input_mode_select}, 7'h01);
      check(hs_mode, 1'b0);
      check({atw_if_i.scl, atw_if_i.sda}, 2'h3);
   endtask
   task t_write();
      logic ack;
      int n0;
      op(atw_pkg::OP_START, 8'h00, 1'b0);
      n0 = scl_rises;
      send({atw_pkg::SLAVE_ADDR, 1'b0}, 1'b0, ack);
      check(ack, 1'b1);
      send(8'hF6, 1'b0, ack);
      check(ack, 1'b1);
      check(scl_rises - n0, 18);
      check({reference_select, polarity_select}, 4'hF);
      send(8'h6A, 1'b0, ack);
      check(ack, 1'b1);
      check({scan_select, channel_select, input_mode_select}, 7'h6A);
      check(polarity_select, 1'b1);
      op(atw_pkg::OP_STOP, 8'h00, 1'b0);
      check(busy, 1'b0);
   endtask
   task t_cfg_reset();
      logic ack;
      op(atw_pkg::OP_START, 8'h00, 1'b0);
      send({atw_pkg::SLAVE_ADDR, 1'b0}, 1'b0, ack);
      send(8'h1E, 1'b0, ack);
      check({scan_select, channel_select, input_mode_select}, 7'h1E);
      send(8'hC6, 1'b0, ack);
      check({scan_select, channel_select, input_mode_select}, 7'h1E);
      check({reference_select, ext_clock_select, polarity_select}, 5'h11);
      send(8'hC4, 1'b0, ack);
      check({scan_select, channel_select, input_mode_select}, 7'h01);
      check({reference_select, ext_clock_select, polarity_select}, 5'h11);
      op(atw_pkg::OP_START, 8'h00, 1'b0);
      op(atw_pkg::OP_STOP, 8'h00, 1'b0);
      check({atw_if_i.scl, atw_if_i.sda}, 2'h3);
   endtask
   task t_wrong();
      logic ack;
      op(atw_pkg::OP_START, 8'h00, 1'b0);
      send({atw_pkg::SLAVE_ADDR ^ 7'h01, 1'b0}, 1'b0, ack);
      check(ack, 1'b0);
      send(8'h00, 1'b0, ack);
      check(ack, 1'b0);
      check({scan_select, channel_select, input_mode_select}, 7'h01);
      op(atw_pkg::OP_STOP, 8'h00, 1'b0);
   endtask
   task t_hs();
      logic ack;
      op(atw_pkg::OP_START, 8'h00, 1'b0);
      send(8'h0D, 1'b0, ack);
      check(ack, 1'b0);
      check(hs_mode, 1'b1);
      op(atw_pkg::OP_START, 8'h00, 1'b1);
      check(hs_mode, 1'b1);
      send({atw_pkg::SLAVE_ADDR, 1'b0}, 1'b1, ack);
      check(ack, 1'b1);
      send(8'h09, 1'b1, ack);
      check({scan_select, channel_select, input_mode_select}, 7'h09);
      op(atw_pkg::OP_STOP, 8'h00, 1'b1);
      check(hs_mode, 1'b0);
   endtask
   task t_read();
      logic ack;
      op(atw_pkg::OP_START, 8'h00, 1'b0);
      send({atw_pkg::SLAVE_ADDR, 1'b1}, 1'b0, ack);
      check(ack, 1'b1);
      check(reads, 1);
      op(atw_pkg::OP_STOP, 8'h00, 1'b0);
      check(busy, 1'b0);
   endtask
   task t_unmapped();
      apb(1'b1, 8'h10, 32'h0000_0001, stat);
      check(last_err, 1'b1);
      apb(1'b0, atw_pkg::STAT_OFFS, 32'h0000_0000, stat);
      check(stat[0], 1'b0);
   endtask
   // clock enable low: a command written meanwhile is lost, lines stay idle
   task t_freeze();
      ce <= 1'b0;
      apb(1'b1, atw_pkg::CMD_OFFS, {16'h0000, 8'h00, 5'h00, 1'b0, atw_pkg::OP_START}, stat);
      repeat (200) @(posedge pclk);
      check({atw_if_i.scl, atw_if_i.sda}, 2'h3);
      ce <= 1'b1;
      apb(1'b0, atw_pkg::STAT_OFFS, 32'h0000_0000, stat);
      check(stat[0], 1'b0);
   endtask
   // main sequence
   initial
   begin
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      repeat (4) @(posedge pclk);
      t_reset();
      t_unmapped();
      t_freeze();
      t_write();
      t_cfg_reset();
      t_wrong();
      t_hs();
      t_read();
      summarize();
   end
endmodule
`default_nettype wire
